/* File: hdl/adcrf_defs.svh */
`ifndef ADCRF_DEFS_SVH
`define ADCRF_DEFS_SVH

// Register offsets on the word address lines.
`define ADCRF_OFS_INT_ENABLE 4'h9
`define ADCRF_OFS_INT_STATUS 4'hA
`define ADCRF_OFS_TIMER 4'hB
`define ADCRF_OFS_FIFO 4'hC
`define ADCRF_OFS_LIMIT 4'hD

// Interrupt enable and status fields.
`define ADCRF_IE_LIMIT_BIT 0
`define ADCRF_IE_FIFO_BIT 2
`define ADCRF_IS_PTR_LSB 8
`define ADCRF_IS_CNT_LSB 11

// Result word fields.
`define ADCRF_LOWRES_NIBBLE 4'hE
`define ADCRF_RES_SIGN_BIT 12

// Reset values.
`define ADCRF_TIMER_RST 16'h0000
`define ADCRF_IE_RST 16'h0000
`define ADCRF_LIMIT_RST 16'h0000

// Timer wait: the prescaler reload and the fixed extra cycles.
`define ADCRF_PRE_RELOAD 5'h1F
`define ADCRF_PRE_ENTRY 5'h01
`define ADCRF_TIMER_EXTRA 2

`endif

/* File: hdl/adcrf_pkg.sv */
package adcrf_pkg;
  typedef enum logic [1:0] {SEQ_REST, SEQ_FETCH, SEQ_TIMER, SEQ_CONVERT} adcrf_seq_state_t;
  typedef logic [15:0] adcrf_word_t;
endpackage

/* File: hdl/adcrf_core.sv */
`timescale 1ns/1ns
`include "adcrf_defs.svh"

// Functional notes
// - Instruction n crossing limit one sets limit flag bit n.
// - Instruction n crossing limit two sets limit flag bit 8+n.
// - Reading the limit flags, or a soft reset, clears every flag.
// - Delay timer is a 16-bit counter behind a 5-bit prescaler.
// - Timer preset holds low byte in bits 0-7, high in 8-15.
// - Timed wait happens only when the instruction's timer enable is set.
// - Timer wait lasts exactly 32 times N plus 2 cycles.
// - DMA request rises when FIFO count equals enabled 5-bit threshold.
// - Interrupt output falls in the cycle the DMA request rises.
// - DMA request drops when the FIFO is read empty.
// - No new DMA request until the FIFO threshold flag is cleared.
// - Read-only FIFO of 32 words of 16 bits, first in first out.
// - Word holds low nibble, eight high bits, sign; low resolution gives 1110.
// - Bits 13-15 hold sign copies or instruction address per config bit.
// - Writing into a full FIFO loses the oldest result.
// - On 8-bit bus high-byte read advances the FIFO, low byte first.
// - Sequencer stops only on pause, cleared start, reset or soft reset.
// - Pointer clears on reset or loop bit, otherwise increments per instruction.
// - Without loop bits the pointer wraps through all eight instructions.
// - Status bits 11-15 report the FIFO word count modulo 32.
// - Reading interrupt status or soft reset clears every interrupt flag.
module adcrf_core #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable; freezes state when low.
  input wire logic bus_rd_in, // One-cycle read strobe.
  input wire logic bus_wr_in, // One-cycle write strobe.
  input wire logic [3:0] bus_addr_in, // Word address.
  input wire logic byte_lane_select_in, // Byte select on the 8-bit bus.
  input wire logic bus_width_select_in, // High selects the 8-bit bus.
  input wire adcrf_pkg::adcrf_word_t bus_wdata_in, // Write data.
  output adcrf_pkg::adcrf_word_t bus_rdata_out, // Read data, one cycle after the strobe.
  input wire logic cfg_start_in, // Sequencer start bit.
  input wire logic cfg_reset_in, // Soft device reset bit.
  input wire logic cfg_addr_tag_in, // High puts the instruction address in bits 13-15.
  input wire logic instr_timer_en_in, // Current instruction uses the timer.
  input wire logic instr_loop_in, // Current instruction is the last of the loop.
  input wire logic instr_pause_in, // Current instruction pauses first.
  input wire logic conv_lowres_in, // Result is of low resolution.
  input wire logic conv_done_in, // One-cycle pulse: conversion finished.
  input wire logic [12:0] conv_result_in, // Sign and twelve result bits.
  input wire logic limit1_hit_in, // Pulse: first limit crossed.
  input wire logic limit2_hit_in, // Pulse: second limit crossed.
  output logic conv_start_out, // One-cycle pulse starting a conversion.
  output logic [2:0] instruction_pointer_out, // Current instruction.
  output logic seq_running_out, // Sequencer is out of rest.
  output logic dma_request_out, // DMA request.
  output logic int_n_out // Interrupt, active low.
);
  import adcrf_pkg::*;

  // ==========================================================
  // Bus decode
  function automatic logic adcrf_hit(input logic [3:0] addr, input logic [3:0] ofs);
    adcrf_hit = (addr == ofs);
  endfunction

  logic rd_fifo, rd_stat, rd_limit, wr_timer, wr_ie, pop;
  assign rd_fifo = bus_rd_in && adcrf_hit(bus_addr_in, `ADCRF_OFS_FIFO);
  assign rd_stat = bus_rd_in && adcrf_hit(bus_addr_in, `ADCRF_OFS_INT_STATUS);
  assign rd_limit = bus_rd_in && adcrf_hit(bus_addr_in, `ADCRF_OFS_LIMIT);
  assign wr_timer = bus_wr_in && adcrf_hit(bus_addr_in, `ADCRF_OFS_TIMER);
  assign wr_ie = bus_wr_in && adcrf_hit(bus_addr_in, `ADCRF_OFS_INT_ENABLE);

  // ==========================================================
  // Writable registers
  adcrf_word_t timer_preset_r, int_enable_r;

  function automatic adcrf_word_t adcrf_merge(input adcrf_word_t old, input adcrf_word_t wd,
                                              input logic bw8, input logic lane);
    adcrf_merge = old;
    if (!bw8)
      adcrf_merge = wd;
    else if (lane)
      adcrf_merge[15:8] = wd[7:0];
    else
      adcrf_merge[7:0] = wd[7:0];
  endfunction

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      timer_preset_r <= `ADCRF_TIMER_RST;
      int_enable_r <= `ADCRF_IE_RST;
    end
    else if (ce_in)
    begin
      if (wr_timer)
        timer_preset_r <= adcrf_merge(timer_preset_r, bus_wdata_in, bus_width_select_in, byte_lane_select_in);
      if (wr_ie)
        int_enable_r <= adcrf_merge(int_enable_r, bus_wdata_in, bus_width_select_in, byte_lane_select_in);
    end
  end

  logic [4:0] fifo_thr;
  logic fifo_ie, limit_ie;
  assign fifo_thr = int_enable_r[15:11];
  assign fifo_ie = int_enable_r[`ADCRF_IE_FIFO_BIT];
  assign limit_ie = int_enable_r[`ADCRF_IE_LIMIT_BIT];

  // ==========================================================
  // Sequencer
  adcrf_seq_state_t state_r;
  logic [2:0] ptr_r;
  logic [15:0] tmr_cnt_r;
  logic [4:0] pre_r;
  logic halted_r, pause_done_r, instr_end;

  assign instr_end = (state_r == SEQ_CONVERT) && conv_done_in;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || (ce_in && cfg_reset_in))
    begin
      state_r <= SEQ_REST;
      ptr_r <= 3'h0;
      halted_r <= 1'b0;
      pause_done_r <= 1'b0;
      conv_start_out <= 1'b0;
      tmr_cnt_r <= 16'h0000;
      pre_r <= 5'h00;
    end
    else if (ce_in)
    begin
      conv_start_out <= 1'b0;
      if (!cfg_start_in)
        halted_r <= 1'b0;
      unique case (state_r)
        SEQ_REST:
          if (cfg_start_in && !halted_r)
            state_r <= SEQ_FETCH;
        SEQ_FETCH:
          if (!cfg_start_in)
            state_r <= SEQ_REST;
          else if (instr_pause_in && !pause_done_r)
          begin
            state_r <= SEQ_REST;
            halted_r <= 1'b1;
            pause_done_r <= 1'b1;
          end
          else if (instr_timer_en_in)
          begin
            state_r <= SEQ_TIMER;
            tmr_cnt_r <= timer_preset_r;
            pre_r <= `ADCRF_PRE_ENTRY;
          end
          else
          begin
            state_r <= SEQ_CONVERT;
            conv_start_out <= 1'b1;
          end
        SEQ_TIMER:
          if (pre_r != 5'h00)
            pre_r <= pre_r - 5'h01;
          else if (tmr_cnt_r != 16'h0000)
          begin
            tmr_cnt_r <= tmr_cnt_r - 16'h0001;
            pre_r <= `ADCRF_PRE_RELOAD;
          end
          else
          begin
            state_r <= SEQ_CONVERT;
            conv_start_out <= 1'b1;
          end
        SEQ_CONVERT:
          if (conv_done_in)
          begin
            ptr_r <= instr_loop_in ? 3'h0 : ptr_r + 3'h1;
            pause_done_r <= 1'b0;
            state_r <= cfg_start_in ? SEQ_FETCH : SEQ_REST;
          end
      endcase
    end
  end

  // ==========================================================
  // Result FIFO
  adcrf_word_t mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] count_r;
  logic full, empty;
  adcrf_word_t wr_word;

  assign full = (count_r == (AW+1)'(DEPTH));
  assign empty = (count_r == '0);
  assign pop = rd_fifo && (!bus_width_select_in || byte_lane_select_in) && !empty;

  always_comb
  begin
    wr_word[3:0] = conv_lowres_in ? `ADCRF_LOWRES_NIBBLE : conv_result_in[3:0];
    wr_word[12:4] = conv_result_in[12:4];
    wr_word[15:13] = cfg_addr_tag_in ? ptr_r : {3{conv_result_in[`ADCRF_RES_SIGN_BIT]}};
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (ce_in && instr_end)
      mem_r[wr_ptr_r] <= wr_word;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else if (ce_in)
    begin
      if (instr_end)
        wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop || (instr_end && full && !pop))
        rd_ptr_r <= rd_ptr_r + AW'(1);
      if (instr_end && !pop && !full)
        count_r <= count_r + (AW+1)'(1);
      else if (pop && !instr_end)
        count_r <= count_r - (AW+1)'(1);
    end
  end

  // ==========================================================
  // Flags, DMA request and interrupt
  logic [15:0] limit_r, limit_set;
  logic fifo_flag_r, limit_flag_r, thr_hit, thr_hit_d_r, thr_event;
  logic fifo_flag_nxt, limit_flag_nxt;
  logic soft_rst;

  assign soft_rst = cfg_reset_in;
  assign thr_hit = fifo_ie && (count_r == {1'b0, fifo_thr}) && (fifo_thr != 5'h00);
  assign thr_event = thr_hit && !thr_hit_d_r;
  always_comb
  begin
    limit_set = 16'h0000;
    limit_set[{1'b0, ptr_r}] = limit1_hit_in;
    limit_set[{1'b1, ptr_r}] = limit2_hit_in;
  end
  assign fifo_flag_nxt = thr_event || (fifo_flag_r && !rd_stat && !soft_rst);
  assign limit_flag_nxt = (|limit_set) || (limit_flag_r && !rd_stat && !soft_rst);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      limit_r <= `ADCRF_LIMIT_RST;
      fifo_flag_r <= 1'b0;
      limit_flag_r <= 1'b0;
      thr_hit_d_r <= 1'b0;
      dma_request_out <= 1'b0;
      int_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      limit_r <= limit_set | ((rd_limit || soft_rst) ? 16'h0000 : limit_r);
      fifo_flag_r <= fifo_flag_nxt;
      limit_flag_r <= limit_flag_nxt;
      thr_hit_d_r <= thr_hit;
      if (thr_event && !fifo_flag_r)
        dma_request_out <= 1'b1;
      else if (empty)
        dma_request_out <= 1'b0;
      int_n_out <= !((fifo_flag_nxt && fifo_ie) || (limit_flag_nxt && limit_ie));
    end
  end

  // ==========================================================
  // Read data
  adcrf_word_t rd_word, head;
  assign head = mem_r[rd_ptr_r];
  always_comb
  begin
    rd_word = 16'h0000;
    unique case (bus_addr_in)
      `ADCRF_OFS_FIFO: rd_word = head;
      `ADCRF_OFS_LIMIT: rd_word = limit_r;
      `ADCRF_OFS_TIMER: rd_word = timer_preset_r;
      `ADCRF_OFS_INT_ENABLE: rd_word = int_enable_r;
      `ADCRF_OFS_INT_STATUS:
      begin
        rd_word[`ADCRF_IE_LIMIT_BIT] = limit_flag_r;
        rd_word[`ADCRF_IE_FIFO_BIT] = fifo_flag_r;
        rd_word[10:8] = ptr_r;
        rd_word[15:11] = count_r[4:0];
      end
      default: rd_word = 16'h0000;
    endcase
    if (bus_width_select_in && byte_lane_select_in)
      rd_word = {8'h00, rd_word[15:8]};
    else if (bus_width_select_in)
      rd_word = {8'h00, rd_word[7:0]};
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      bus_rdata_out <= 16'h0000;
      instruction_pointer_out <= 3'h0;
      seq_running_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (bus_rd_in)
        bus_rdata_out <= rd_word;
      instruction_pointer_out <= (cfg_reset_in || instr_end && instr_loop_in) ? 3'h0 :
                                 (instr_end ? ptr_r + 3'h1 : ptr_r);
      seq_running_out <= (state_r != SEQ_REST);
    end
  end

  // ==========================================================
  // Checks
  logic [21:0] tw_cnt_r;
  logic [15:0] tw_n_r;
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      tw_cnt_r <= '0;
      tw_n_r <= '0;
    end
    else if (ce_in)
    begin
      tw_cnt_r <= (state_r == SEQ_TIMER) ? tw_cnt_r + 22'h1 : 22'h0;
      if (state_r == SEQ_FETCH)
        tw_n_r <= timer_preset_r;
    end
  end

  chk_timer_length: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && state_r == SEQ_TIMER && !cfg_reset_in ##1 state_r == SEQ_CONVERT |->
    $past(tw_cnt_r) + 22'h1 == {tw_n_r, 5'h00} + 22'(`ADCRF_TIMER_EXTRA))
    else $error("Timer wait length wrong");
  chk_timer_skip: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && state_r == SEQ_FETCH && cfg_start_in && !cfg_reset_in && !instr_pause_in && !instr_timer_en_in
    |=> state_r == SEQ_CONVERT && conv_start_out)
    else $error("Timer not skipped");
  chk_ptr_loop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && instr_end && instr_loop_in && !cfg_reset_in |=> ptr_r == 3'h0)
    else $error("Loop did not clear pointer");
  chk_ptr_step: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && instr_end && !instr_loop_in && !cfg_reset_in |=> ptr_r == $past(ptr_r) + 3'h1)
    else $error("Pointer did not advance");
  chk_limit_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && rd_limit && !limit1_hit_in && !limit2_hit_in |=> limit_r == 16'h0000)
    else $error("Limit flags not cleared");
  chk_limit_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && limit2_hit_in |=> limit_r[{1'b1, $past(ptr_r)}])
    else $error("Limit two flag not set");
  chk_dma_rise: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(dma_request_out) |-> !int_n_out || !fifo_ie)
    else $error("Interrupt not with DMA request");
  chk_dma_drop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && empty && !thr_event |=> !dma_request_out)
    else $error("DMA request held on empty FIFO");
  chk_fifo_sat: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && full && instr_end && !pop |=> full)
    else $error("Overflow changed count");
  chk_dma_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ce_in && fifo_flag_r && !dma_request_out |=> !dma_request_out)
    else $error("DMA request while flag set");

  cov_overflow: cover property (@(posedge clk_sys_in) full && instr_end);
  cov_dma: cover property (@(posedge clk_sys_in) $rose(dma_request_out) ##[1:200] !dma_request_out);
  cov_timer: cover property (@(posedge clk_sys_in) state_r == SEQ_TIMER ##1 state_r == SEQ_CONVERT);
endmodule

/* File: testbench/adcrf_host.sv */
`timescale 1ns/1ns
// ====================================
// Host processor on the strobed word bus
// ====================================
module adcrf_host (
  input wire logic clk_sys_in, // System clock.
  input wire adcrf_pkg::adcrf_word_t rdata_in, // Read data.
  output logic rd_out, // Read strobe.
  output logic wr_out, // Write strobe.
  output logic [3:0] addr_out, // Word address.
  output logic lane_out, // Byte select.
  output adcrf_pkg::adcrf_word_t wdata_out // Write data.
);
  import adcrf_pkg::*;
  initial
  begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 4'h0;
    lane_out = 1'b0;
    wdata_out = 16'h0000;
  end

  // A released bus shows the inverse of its last address, lane and data, never a stale copy.
  task automatic access(input logic w, input logic [3:0] a, input logic l, input adcrf_word_t d,
    output adcrf_word_t q);
    @(posedge clk_sys_in);
    #1;
    rd_out = !w;
    wr_out = w;
    addr_out = a;
    lane_out = l;
    wdata_out = d;
    @(posedge clk_sys_in);
    #1;
    q = rdata_in;
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = ~a;
    lane_out = ~l;
    wdata_out = ~d;
  endtask

  task automatic get_result(input logic bw8, output adcrf_word_t w);
    adcrf_word_t lo;
    adcrf_word_t hi;
    access(1'b0, 4'hC, 1'b0, 16'h0000, lo);
    if (bw8)
    begin
      access(1'b0, 4'hC, 1'b1, 16'h0000, hi);
      lo = {hi[7:0], lo[7:0]};
    end
    w = lo;
  endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import adcrf_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic bw = 1'b0;
  logic cfg_start_in = 1'b0;
  logic cfg_reset_in = 1'b0;
  logic cfg_addr_tag_in = 1'b0;
  logic instr_timer_en_in = 1'b0;
  logic instr_loop_in = 1'b0;
  logic instr_pause_in = 1'b0;
  logic conv_lowres_in = 1'b0;
  logic conv_done_in = 1'b0;
  logic [12:0] conv_result_in = 13'h0000;
  logic limit1_hit_in = 1'b0;
  logic limit2_hit_in = 1'b0;
  logic rd, wr, lane, conv_start_out, dma_request_out, int_n_out, seq_running_out;
  logic [3:0] addr;
  logic [2:0] instruction_pointer_out;
  logic [2:0] ptr_exp = 3'h0;
  adcrf_word_t wdata, rdata, v;
  adcrf_word_t q[$];
  int n_errors = 0;
  int checks = 0;
  int gap, base;

  always #25 clk_sys_in = ~clk_sys_in;

  adcrf_host u_adcrf_host (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .rd_out(rd), .wr_out(wr),
    .addr_out(addr), .lane_out(lane), .wdata_out(wdata));

  adcrf_core u_adcrf_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1), .bus_rd_in(rd),
    .bus_wr_in(wr), .bus_addr_in(addr), .byte_lane_select_in(lane), .bus_width_select_in(bw),
    .bus_wdata_in(wdata), .bus_rdata_out(rdata), .cfg_start_in(cfg_start_in), .cfg_reset_in(cfg_reset_in),
    .cfg_addr_tag_in(cfg_addr_tag_in), .instr_timer_en_in(instr_timer_en_in), .instr_loop_in(instr_loop_in),
    .instr_pause_in(instr_pause_in), .conv_lowres_in(conv_lowres_in), .conv_done_in(conv_done_in),
    .conv_result_in(conv_result_in), .limit1_hit_in(limit1_hit_in), .limit2_hit_in(limit2_hit_in),
    .conv_start_out(conv_start_out), .instruction_pointer_out(instruction_pointer_out),
    .seq_running_out(seq_running_out), .dma_request_out(dma_request_out), .int_n_out(int_n_out));

  // ====================================
  // Shared tasks
  // ====================================
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input adcrf_word_t seen, input adcrf_word_t exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_reg(input string name, input logic [3:0] a, input adcrf_word_t exp);
    u_adcrf_host.access(1'b0, a, 1'b0, 16'h0000, v);
    chk(name, v, exp);
  endtask

  task automatic wr_reg(input logic [3:0] a, input adcrf_word_t d);
    u_adcrf_host.access(1'b1, a, 1'b0, d, v);
  endtask

  task automatic wait_start(output int n);
    n = 0;
    while (conv_start_out !== 1'b1)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
      if (n > 4000)
      begin
        n_errors++;
        print_verdict();
      end
    end
  endtask

  // Ends the conversion in flight and waits for the next one to start.
  task automatic conv(input logic [12:0] r);
    if (q.size() == 32)
      v = q.pop_front();
    q.push_back({cfg_addr_tag_in ? ptr_exp : {3{r[12]}}, r[12:4], conv_lowres_in ? 4'hE : r[3:0]});
    ptr_exp = instr_loop_in ? 3'h0 : ptr_exp + 3'h1;
    conv_done_in = 1'b1;
    conv_result_in = r;
    @(posedge clk_sys_in);
    #1;
    conv_done_in = 1'b0;
    conv_result_in = ~r;
    wait_start(gap);
    chk("pointer", 16'(instruction_pointer_out), 16'(ptr_exp));
  endtask

  task automatic drain(input int n);
    repeat (n)
    begin
      u_adcrf_host.get_result(bw, v);
      chk("fifo word", v, q.pop_front());
    end
  endtask

  task automatic pulse_limits();
    limit1_hit_in = 1'b1;
    limit2_hit_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    limit1_hit_in = 1'b0;
    limit2_hit_in = 1'b0;
  endtask

  // ====================================
  // Main sequence
  // ====================================
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    chk_reg("preset", 4'hB, 16'h0000);
    chk_reg("limits", 4'hD, 16'h0000);
    chk_reg("status", 4'hA, 16'h0000);
    chk_reg("unmapped", 4'h3, 16'h0000);
    wr_reg(4'hB, 16'hA51C);
    chk_reg("preset", 4'hB, 16'hA51C);
    chk("idle", 16'(seq_running_out), 16'h0000);
    cfg_start_in = 1'b1;
    wait_start(gap);
    chk("running", 16'(seq_running_out), 16'h0001);
    for (int i = 0; i < 10; i++)
    begin
      conv_lowres_in = i[0];
      cfg_addr_tag_in = i[1];
      instr_loop_in = (i == 9);
      conv(13'(i * 1187 + 421));
    end
    instr_loop_in = 1'b0;
    base = gap;
    drain(10);
    for (int n = 0; n < 4; n += 3)
    begin
      wr_reg(4'hB, 16'(n));
      instr_timer_en_in = 1'b1;
      conv(13'h1ABC);
      instr_timer_en_in = 1'b0;
      chk("wait cycles", 16'(gap - base), 16'(32 * n + 2));
    end
    drain(2);
    wr_reg(4'h9, 16'h1804);
    u_adcrf_host.access(1'b0, 4'hA, 1'b0, 16'h0000, v);
    repeat (2) conv(13'h0F0F);
    chk("dma", 16'(dma_request_out), 16'h0000);
    conv(13'h10F0);
    chk("dma", 16'(dma_request_out), 16'h0001);
    chk("irq", 16'(int_n_out), 16'h0000);
    chk_reg("status", 4'hA, {5'h03, ptr_exp, 8'h04});
    chk("irq", 16'(int_n_out), 16'h0001);
    drain(3);
    @(posedge clk_sys_in);
    #1;
    chk("dma", 16'(dma_request_out), 16'h0000);
    repeat (3) conv(13'h0123);
    chk("dma", 16'(dma_request_out), 16'h0001);
    drain(3);
    repeat (3) conv(13'h1321);
    chk("dma", 16'(dma_request_out), 16'h0000);
    u_adcrf_host.access(1'b0, 4'hA, 1'b0, 16'h0000, v);
    drain(3);
    wr_reg(4'h9, 16'h0000);
    pulse_limits();
    chk_reg("limits", 4'hD, 16'h0101 << ptr_exp);
    chk_reg("limits", 4'hD, 16'h0000);
    wr_reg(4'hC, 16'h5A5A);
    for (int i = 0; i < 33; i++)
      conv(13'(i * 517 + 99));
    drain(30);
    bw = 1'b1;
    drain(1);
    u_adcrf_host.access(1'b0, 4'hA, 1'b1, 16'h0000, v);
    chk("status high", v, {8'h00, 5'h01, ptr_exp});
    u_adcrf_host.access(1'b0, 4'hC, 1'b1, 16'h0000, v);
    chk("high first", v, q.pop_front() >> 8);
    u_adcrf_host.access(1'b1, 4'hB, 1'b0, 16'h77C3, v);
    u_adcrf_host.access(1'b1, 4'hB, 1'b1, 16'hFF5E, v);
    bw = 1'b0;
    chk_reg("preset bytes", 4'hB, 16'h5EC3);
    pulse_limits();
    instr_pause_in = 1'b1;
    cfg_reset_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    cfg_reset_in = 1'b0;
    chk_reg("limits", 4'hD, 16'h0000);
    chk_reg("status", 4'hA, 16'h0000);
    chk("paused", 16'(seq_running_out), 16'h0000);
    cfg_start_in = 1'b0;
    @(posedge clk_sys_in);
    #1;
    cfg_start_in = 1'b1;
    wait_start(gap);
    chk("resume cycles", 16'(gap), 16'h0002);
    chk("running", 16'(seq_running_out), 16'h0001);
    print_verdict();
  end
endmodule
